// ===== rtl/emst_strobe_timing.sv
// Purpose: Sequences one external move with programmed strobe timing
// Assumes: One request at a time; request accepted only when ready
// Notes:   Data pins released during read strobes and when idle
`timescale 1ns/1ps
module emst_strobe_timing
    import emst_pkg::*;
(
    input  wire logic            sys_clk_in,
    input  wire logic            rst_in,
    input  wire logic [2:0]      config_in,
    input  wire emst_timing_type timing_in,
    input  wire logic            req_valid_in,
    input  wire emst_req_type    req_in,
    output logic                 req_ready_out,
    output logic                 done_out,
    output logic [7:0]           rdata_out,
    input  wire logic [7:0]      data_pin_in,
    output emst_pin_type         pins_out
);

    // ------------------------------------------------------------
    // State and registers
    // ------------------------------------------------------------
    emst_state_type   state_reg;
    emst_req_type     req_reg;
    emst_timing_type  tim_reg;
    logic             mux_reg;
    logic             bank_reg;
    logic [4:0]       cnt_reg;
    logic [7:0]       din_meta_reg;
    logic [7:0]       din_sync_reg;
    logic [7:0]       rdata_reg;
    logic             done_reg;
    emst_pin_type     pins_reg;
    logic             mux_dec;
    logic             en_dec;
    logic             bank_dec;
    logic             last;

    emst_mode_decode u_decode (
        .config_in   (config_in),
        .wide_in     (req_in.wide),
        .mux_out     (mux_dec),
        .enabled_out (en_dec),
        .bank_out    (bank_dec)
    );

    function automatic logic [4:0] width_cycles(input logic [3:0] code);
        width_cycles = {1'b0, code} + 5'h01;
    endfunction : width_cycles

    assign req_ready_out = (state_reg == ST_IDLE) && en_dec;
    assign last          = (cnt_reg == CNT_ZERO);
    assign done_out      = done_reg;
    assign rdata_out     = rdata_reg;

    // ------------------------------------------------------------
    // Read data pin synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            din_meta_reg <= 8'h00;
            din_sync_reg <= 8'h00;
        end
        else
        begin
            din_meta_reg <= data_pin_in;
            din_sync_reg <= din_meta_reg;
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            state_reg <= ST_IDLE;
            cnt_reg   <= CNT_ZERO;
            req_reg   <= '0;
            tim_reg   <= '0;
            mux_reg   <= 1'b0;
            bank_reg  <= 1'b0;
        end
        else
        begin
            case (state_reg)
                ST_IDLE:
                begin
                    if (req_valid_in && en_dec)
                    begin
                        req_reg  <= req_in;
                        tim_reg  <= timing_in;
                        mux_reg  <= mux_dec;
                        bank_reg <= bank_dec;
                        if (mux_dec)
                        begin
                            state_reg <= ST_ALE_HIGH;
                            cnt_reg   <= {3'h0, ALE_HIGH_M1};
                        end
                        else if (timing_in.setup != 2'h0)
                        begin
                            state_reg <= ST_SETUP;
                            cnt_reg   <= {3'h0, timing_in.setup} - 5'h01;
                        end
                        else
                        begin
                            state_reg <= ST_STROBE;
                            cnt_reg   <= width_cycles(timing_in.width)
                                         - 5'h01;
                        end
                    end
                end
                ST_ALE_HIGH:
                begin
                    if (last)
                    begin
                        state_reg <= ST_ALE_LOW;
                        cnt_reg   <= {3'h0, ALE_LOW_M1};
                    end
                    else
                        cnt_reg <= cnt_reg - 5'h01;
                end
                ST_ALE_LOW:
                begin
                    if (!last)
                        cnt_reg <= cnt_reg - 5'h01;
                    else if (tim_reg.setup != 2'h0)
                    begin
                        state_reg <= ST_SETUP;
                        cnt_reg   <= {3'h0, tim_reg.setup} - 5'h01;
                    end
                    else
                    begin
                        state_reg <= ST_STROBE;
                        cnt_reg   <= width_cycles(tim_reg.width) - 5'h01;
                    end
                end
                ST_SETUP:
                begin
                    if (last)
                    begin
                        state_reg <= ST_STROBE;
                        cnt_reg   <= width_cycles(tim_reg.width) - 5'h01;
                    end
                    else
                        cnt_reg <= cnt_reg - 5'h01;
                end
                ST_STROBE:
                begin
                    if (!last)
                        cnt_reg <= cnt_reg - 5'h01;
                    else if (tim_reg.hold != 2'h0)
                    begin
                        state_reg <= ST_HOLD;
                        cnt_reg   <= {3'h0, tim_reg.hold} - 5'h01;
                    end
                    else
                        state_reg <= ST_IDLE;
                end
                ST_HOLD:
                begin
                    if (last)
                        state_reg <= ST_IDLE;
                    else
                        cnt_reg <= cnt_reg - 5'h01;
                end
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Read capture and completion
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            rdata_reg <= 8'h00;
            done_reg  <= 1'b0;
        end
        else
        begin
            done_reg <= 1'b0;
            if (state_reg == ST_STROBE && last)
            begin
                if (!req_reg.write)
                    rdata_reg <= din_sync_reg;
                if (tim_reg.hold == 2'h0)
                    done_reg <= 1'b1;
            end
            if (state_reg == ST_HOLD && last)
                done_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    always_comb
    begin
        pins_out = pins_reg;
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            pins_reg <= '{addr: 16'h0000, data: 8'h00,
                          data_drive_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1,
                          ale: 1'b0, bank_drive_n: 1'b1};
        end
        else
        begin
            pins_reg.ale <= 1'b0;
            pins_reg.wr_n <= 1'b1;
            pins_reg.rd_n <= 1'b1;
            case (state_reg)
                ST_IDLE:
                begin
                    pins_reg.data_drive_n <= 1'b1;
                    pins_reg.bank_drive_n <= 1'b1;
                    if (req_valid_in && en_dec)
                    begin
                        pins_reg.addr         <= req_in.addr;
                        pins_reg.bank_drive_n <= ~bank_dec;
                        if (mux_dec)
                        begin
                            pins_reg.ale          <= 1'b1;
                            pins_reg.data         <= req_in.addr[7:0];
                            pins_reg.data_drive_n <= 1'b0;
                        end
                        else if (req_in.write)
                        begin
                            pins_reg.data         <= req_in.wdata;
                            pins_reg.data_drive_n <= 1'b0;
                        end
                        if (!mux_dec && timing_in.setup == 2'h0)
                        begin
                            pins_reg.wr_n <= ~req_in.write;
                            pins_reg.rd_n <= req_in.write;
                        end
                    end
                end
                ST_ALE_HIGH:
                    pins_reg.ale <= ~last;
                ST_ALE_LOW:
                begin
                    if (last)
                    begin
                        pins_reg.data         <= req_reg.wdata;
                        pins_reg.data_drive_n <= ~req_reg.write;
                        if (tim_reg.setup == 2'h0)
                        begin
                            pins_reg.wr_n <= ~req_reg.write;
                            pins_reg.rd_n <= req_reg.write;
                        end
                    end
                end
                ST_SETUP:
                begin
                    if (last)
                    begin
                        pins_reg.wr_n <= ~req_reg.write;
                        pins_reg.rd_n <= req_reg.write;
                    end
                end
                ST_STROBE:
                begin
                    if (!last)
                    begin
                        pins_reg.wr_n <= ~req_reg.write;
                        pins_reg.rd_n <= req_reg.write;
                    end
                    else if (tim_reg.hold == 2'h0)
                    begin
                        pins_reg.data_drive_n <= 1'b1;
                        pins_reg.bank_drive_n <= 1'b1;
                    end
                end
                ST_HOLD:
                begin
                    if (last)
                    begin
                        pins_reg.data_drive_n <= 1'b1;
                        pins_reg.bank_drive_n <= 1'b1;
                    end
                end
                default:
                begin
                    pins_reg.data_drive_n <= 1'b1;
                    pins_reg.bank_drive_n <= 1'b1;
                end
            endcase
        end
    end

endmodule : emst_strobe_timing

// ===== rtl/emst_pkg.sv
// Purpose: Constants and types for the external bus strobe timing unit
// Assumes: Single 100 MHz core clock, synchronous active-high reset
// Notes:   Notes on behaviour follow
//
// Notes on behaviour
// - Width code 1110 gives a 15-cycle strobe, 1111 gives 16 cycles.
// - Two-bit hold code keeps address valid 0 to 3 cycles after strobe.
// - Config 101, 110, 111 use non-multiplexed pins for 8-bit and 16-bit moves.
// - Config 110 makes 8-bit moves drive upper address byte as bank.
// - Config 001, 010, 011 share low address byte with data pins.
// - Config 001 or 011 makes 8-bit moves drive no bank select.
// - Multiplexed latch strobe high 1 to 4 cycles, then low 1 to 4.
// - Address and control lead the strobe by 0 to 3 setup cycles.
// - Write data valid 1 to 19 cycles before write strobe ends.
// - Write data stays driven 0 to 3 cycles after write strobe ends.
// - Four-bit width field sets strobe width as code plus one.
// - Two-bit setup field sets setup cycles; code 10 gives two.
package emst_pkg;

    // ------------------------------------------------------------
    // Configuration layout
    // ------------------------------------------------------------
    localparam int HOLD_LSB  = 0;
    localparam int WIDTH_LSB = 2;
    localparam int SETUP_LSB = 6;

    localparam logic [2:0] MODE_MUX_A   = 3'h1;
    localparam logic [2:0] MODE_MUX_B   = 3'h2;
    localparam logic [2:0] MODE_MUX_C   = 3'h3;
    localparam logic [2:0] MODE_NMX_A   = 3'h5;
    localparam logic [2:0] MODE_NMX_B   = 3'h6;
    localparam logic [2:0] MODE_NMX_C   = 3'h7;
    localparam logic [2:0] CFG_RESET    = 3'h0;

    // Latch strobe high and low times, cycles (1..4)
    localparam logic [1:0] ALE_HIGH_M1  = 2'h0;
    localparam logic [1:0] ALE_LOW_M1   = 2'h0;
    localparam logic [4:0] CNT_ZERO     = 5'h00;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ALE_HIGH,
        ST_ALE_LOW,
        ST_SETUP,
        ST_STROBE,
        ST_HOLD
    } emst_state_type;

    typedef struct packed {
        logic        write;
        logic        wide;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } emst_req_type;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  data;
        logic        data_drive_n;
        logic        wr_n;
        logic        rd_n;
        logic        ale;
        logic        bank_drive_n;
    } emst_pin_type;

    typedef struct packed {
        logic [1:0] setup;
        logic [3:0] width;
        logic [1:0] hold;
    } emst_timing_type;

endpackage : emst_pkg

// ===== rtl/emst_mode_decode.sv
// Purpose: Decode interface configuration into bus manner flags
// Assumes: Configuration field is stable while a move runs
// Notes:   Pure combinational
`timescale 1ns/1ps
module emst_mode_decode
    import emst_pkg::*;
(
    input  wire logic [2:0] config_in,
    input  wire logic       wide_in,
    output logic            mux_out,
    output logic            enabled_out,
    output logic            bank_out
);

    always_comb
    begin
        mux_out     = 1'b0;
        enabled_out = 1'b0;
        bank_out    = 1'b0;
        case (config_in)
            MODE_MUX_A, MODE_MUX_C:
            begin
                mux_out     = 1'b1;
                enabled_out = 1'b1;
                bank_out    = wide_in;
            end
            MODE_MUX_B:
            begin
                mux_out     = 1'b1;
                enabled_out = 1'b1;
                bank_out    = 1'b1;
            end
            MODE_NMX_A, MODE_NMX_C:
            begin
                enabled_out = 1'b1;
                bank_out    = wide_in;
            end
            MODE_NMX_B:
            begin
                enabled_out = 1'b1;
                bank_out    = 1'b1;
            end
            default:
            begin
                mux_out     = 1'b0;
                enabled_out = 1'b0;
                bank_out    = 1'b0;
            end
        endcase
    end

endmodule : emst_mode_decode

// ===== verification/emst_sva.sv
// Purpose: Port checks for the strobe timing unit
// Assumes: Config and timing stay stable while a move runs
// Notes:   Bound to emst_strobe_timing
`timescale 1ns/1ps
module emst_sva
    import emst_pkg::*;
(
    input wire logic            sys_clk_in,
    input wire logic            rst_in,
    input wire logic [2:0]      config_in,
    input wire emst_timing_type timing_in,
    input wire logic            req_valid_in,
    input wire emst_req_type    req_in,
    input wire logic            req_ready_out,
    input wire logic            done_out,
    input wire logic [7:0]      rdata_out,
    input wire logic [7:0]      data_pin_in,
    input wire emst_pin_type    pins_out
);
    // ------------------------------------------------------------
    // Cycle counters around each strobe
    // ------------------------------------------------------------
    logic       stb;
    logic       acc;
    logic       wr_reg;
    logic [4:0] lead_reg;
    logic [4:0] wid_reg;
    logic [2:0] post_reg;
    assign stb = !(pins_out.wr_n && pins_out.rd_n);
    assign acc = req_valid_in && req_ready_out;
    always_ff @(posedge sys_clk_in)
    begin
        lead_reg <= acc ? 5'h01 : lead_reg + 5'h01;
        wid_reg  <= stb ? wid_reg + 5'h01 : 5'h00;
        wr_reg   <= stb ? !pins_out.wr_n : wr_reg;
        post_reg <= rst_in ? 3'h7 : stb ? 3'h0
                  : post_reg + {2'h0, post_reg != 3'h7};
    end
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    chk_strobe_width: assert property ($fell(stb) |->
        wid_reg == 5'(timing_in.width) + 5'h01) else $error("width");
    chk_setup_lead: assert property ($rose(stb) |->
        lead_reg == 5'(timing_in.setup) + (config_in[2] ? 5'h01 : 5'h03))
        else $error("setup lead");
    chk_addr_hold: assert property (!stb && !req_ready_out &&
        post_reg < {1'b0, timing_in.hold} |-> $stable(pins_out.addr))
        else $error("address hold");
    chk_wdata_hold: assert property (!stb && !req_ready_out &&
        wr_reg && post_reg < {1'b0, timing_in.hold}
        |-> !pins_out.data_drive_n) else $error("write data hold");
    chk_wdata_setup: assert property (!pins_out.wr_n &&
        !$past(pins_out.wr_n) |-> !pins_out.data_drive_n
        && $stable(pins_out.data)) else $error("write data setup");
    chk_read_release: assert property (!pins_out.rd_n |->
        pins_out.data_drive_n) else $error("read drive");
    chk_ale_width: assert property ($rose(pins_out.ale) |=>
        !pins_out.ale [*2]) else $error("latch strobe");
    chk_ale_addr: assert property (pins_out.ale |-> !config_in[2] &&
        !pins_out.data_drive_n && pins_out.data == pins_out.addr[7:0])
        else $error("muxed address");
    chk_bank_fixed: assert property (stb && config_in == 3'h6 |->
        !pins_out.bank_drive_n) else $error("bank select");
    chk_off_refuse: assert property (config_in[1:0] == 2'h0 |->
        !req_ready_out) else $error("disabled ready");
    cov_long: cover property ($fell(stb) && wid_reg == 5'h10);
    cov_ale: cover property ($rose(pins_out.ale));
    cov_hold: cover property (wr_reg && post_reg == 3'h2 && !req_ready_out);
endmodule : emst_sva
bind emst_strobe_timing emst_sva i_emst_sva (.sys_clk_in, .rst_in,
    .config_in, .timing_in, .req_valid_in, .req_in, .req_ready_out,
    .done_out, .rdata_out, .data_pin_in, .pins_out);

// ===== verification/emst_mem_model.sv
// Purpose: External asynchronous memory on the far side of the pins
// Assumes: Low address byte latched while the latch strobe is high
// Notes:   Slow mode delays read data by two strobe cycles
`timescale 1ns/1ps
module emst_mem_model
    import emst_pkg::*;
(
    input wire logic         sys_clk_in,
    input wire logic         mux_in,
    input wire logic         slow_in,
    input wire emst_pin_type pins_in,
    output logic [7:0]       bus_out
);
    // ------------------------------------------------------------
    // Storage and data line
    // ------------------------------------------------------------
    logic [7:0] mem [256];
    logic [7:0] lat_reg;
    logic [7:0] last_reg = 8'h5A;
    logic [2:0] lag_reg;
    logic [7:0] idx;
    logic       rd_ok;
    assign idx   = mux_in ? lat_reg : pins_in.addr[7:0];
    assign rd_ok = !pins_in.rd_n && (!slow_in || lag_reg > 3'h1);
    always_ff @(posedge sys_clk_in)
    begin
        if (pins_in.ale)
            lat_reg <= pins_in.data;
        if (!pins_in.wr_n)
            mem[idx] <= pins_in.data;
        lag_reg  <= pins_in.rd_n ? 3'h0 : lag_reg + {2'h0, lag_reg != 3'h7};
        last_reg <= bus_out;
    end
    always_comb
    begin
        if (!pins_in.data_drive_n)
            bus_out = pins_in.data;
        else if (rd_ok)
            bus_out = mem[idx];
        else
            bus_out = ~last_reg;
    end
endmodule : emst_mem_model

// ===== verification/testbench.sv
// Purpose: Self-checking bench for the strobe timing unit
// Assumes: One move at a time, inputs changed at rising edges
// Notes:   Pin timing also watched by the bound checker
`timescale 1ns/1ps
module testbench
    import emst_pkg::*;
;
    // ------------------------------------------------------------
    // Stimulus, model and tests
    // ------------------------------------------------------------
    logic            clk = 1'b0;
    logic            rst = 1'b1;
    logic            valid = 1'b0;
    logic            slow = 1'b0;
    logic [2:0]      cfg = 3'h5;
    emst_timing_type tim = '0;
    emst_req_type    req = '0;
    logic            ready;
    logic            done;
    logic [7:0]      rdata;
    logic [7:0]      bus;
    emst_pin_type    pins;
    int              n_errors = 0;
    int              total_checks = 0;
    int              lead;
    int              wid;
    logic            ale_seen;
    logic            bank_seen;
    logic [2:0]      modes [6] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h6, 3'h7};
    logic [3:0]      codes [4] = '{4'h0, 4'h1, 4'hE, 4'hF};

    always #5 clk = ~clk;

    emst_strobe_timing i_emst_strobe_timing (
        .sys_clk_in    (clk),
        .rst_in        (rst),
        .config_in     (cfg),
        .timing_in     (tim),
        .req_valid_in  (valid),
        .req_in        (req),
        .req_ready_out (ready),
        .done_out      (done),
        .rdata_out     (rdata),
        .data_pin_in   (bus),
        .pins_out      (pins)
    );
    emst_mem_model i_emst_mem_model (
        .sys_clk_in (clk),
        .mux_in     (!cfg[2]),
        .slow_in    (slow),
        .pins_in    (pins),
        .bus_out    (bus)
    );

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic move(input logic w, input logic wd,
                        input logic [15:0] a, input logic [7:0] d);
        int n;
        n = 0;
        lead = 0;
        wid = 0;
        ale_seen = 1'b0;
        bank_seen = 1'b0;
        @(posedge clk);
        valid <= 1'b1;
        req   <= '{w, wd, a, d};
        @(negedge clk);
        while (ready !== 1'b1 && n < 20)
        begin
            n++;
            @(negedge clk);
        end
        @(posedge clk);
        valid <= 1'b0;
        do
        begin
            @(negedge clk);
            n++;
            ale_seen |= pins.ale;
            if (!(pins.wr_n && pins.rd_n))
            begin
                wid++;
                bank_seen = !pins.bank_drive_n;
            end
            else if (wid == 0)
                lead++;
        end while (done !== 1'b1 && n < 80);
        check({15'h0, done}, 16'h1);
    endtask : move

    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : conclude

    initial
    begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        for (int k = 0; k < 6; k++)
        begin
            @(posedge clk);
            cfg <= modes[k];
            tim <= '{2'h1, 4'h4, 2'h1};
            move(1'b1, 1'b0, 16'hA500 + 16'(k), 8'h3C + 8'(k));
            check(16'(lead), modes[k][2] ? 16'h1 : 16'h3);
            check({15'h0, ale_seen}, {15'h0, !modes[k][2]});
            check({15'h0, bank_seen}, {15'h0, modes[k][1:0] == 2'h2});
            move(1'b0, 1'b1, 16'hA500 + 16'(k), 8'h00);
            check({8'h0, rdata}, {8'h0, 8'h3C + 8'(k)});
            check({15'h0, bank_seen}, 16'h1);
        end
        $display("mode test finished");
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk);
            cfg  <= 3'h5;
            slow <= i > 1;
            tim  <= '{2'(i), codes[i], 2'(i)};
            move(1'b1, 1'b0, 16'h0040 + 16'(i), 8'h81 + 8'(i));
            check(16'(wid), {12'h0, codes[i]} + 16'h1);
            check(16'(lead), 16'(i));
            @(posedge clk);
            // Reads need three strobe cycles to clear the pin synchroniser
            tim  <= '{2'(i), codes[i] | 4'h2, 2'(i)};
            move(1'b0, 1'b0, 16'h0040 + 16'(i), 8'h00);
            check({8'h0, rdata}, {8'h0, 8'h81 + 8'(i)});
        end
        $display("timing test finished");
        for (int j = 0; j < 2; j++)
        begin
            @(posedge clk);
            cfg   <= 3'(j * 4);
            valid <= 1'b1;
            repeat (4) @(negedge clk);
            check({14'h0, ready, done}, 16'h0);
            @(posedge clk);
            valid <= 1'b0;
        end
        $display("refusal test finished");
        conclude();
    end

    initial
    begin
        #50us;
        n_errors++;
        conclude();
    end
endmodule : testbench
